/* rtl/queued_serial_master_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module queued_serial_master_queue
  import queue_serial_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkClk,
  // Configuration levels
  input wire ctrl_t ctrl,
  // Port enable
  input wire logic enableSet,
  input wire logic enableClear,
  output logic portEnable,
  // Queue pointers
  input wire logic ptrWrite,
  input wire logic [3:0] startPtrIn,
  input wire logic [3:0] endPtrIn,
  output logic [3:0] queueStartPointer,
  output logic [3:0] queueEndPointer,
  output logic [3:0] completedEntryPointer,
  // Status
  input wire logic doneClear,
  input wire logic faultClear,
  output logic queueDoneFlag,
  output logic modeFaultFlag,
  output logic doneIrq,
  // Host RAM access
  input wire logic hostWrite,
  input wire logic [1:0] hostSeg,
  input wire logic [3:0] hostIndex,
  input wire logic [15:0] hostWrData,
  output logic [15:0] hostRdData,
  // Serial pins
  input wire pins_t pinIn,
  output pins_t pinOut,
  output pins_t pinOe
);

  typedef struct packed {
    state_t st;
    logic en;
    logic [3:0] startPtr;
    logic [3:0] endPtr;
    logic [3:0] workPtr;
    logic [3:0] cptPtr;
    logic pendStart;
    logic doneFlag;
    logic faultFlag;
    logic irq;
    logic [ENTRIES-1:0][7:0] cmdMem;
    logic [ENTRIES-1:0][WORD_W-1:0] txMem;
    logic [ENTRIES-1:0][WORD_W-1:0] rxMem;
    logic [WORD_W-1:0] rdData;
    logic [7:0] cmd;
    logic [4:0] len;
    logic [WORD_W-1:0] txSh;
    logic [WORD_W-1:0] rxSh;
    logic [5:0] edgeCnt;
    logic [7:0] timer;
    logic sck;
    logic [3:0] pcs;
    logic [1:0] misoSync;
    logic [1:0] ssSync;
    logic ssLast;
    logic [1:0] ownSelLow;
    logic [WORD_W-1:0] slaveTx;
  } core_t;

  core_t state_reg;
  core_t state_next;
  logic [4:0] linkCnt_reg;
  logic [WORD_W-1:0] linkRx_reg;
  logic ssIdle;
  logic fin;
  logic [WORD_W-1:0] finData;
  logic leading;
  logic sampleNow;
  logic shiftNow;
  logic [4:0] slaveIdx;
  logic slaveBit;
  pins_t drive;
  pins_t driveEn;

  function automatic logic [4:0] lenOf(input logic [7:0] c, input logic [3:0] bits);
    logic [4:0] l;
    l = DEFAULT_LEN;
    if (c[CMD_LENSEL_BIT]) begin
      if (bits == 4'h0) begin
        l = MAX_LEN;
      end else if (bits[3]) begin
        l = {1'b0, bits};
      end
    end
    return l;
  endfunction

  function automatic logic [WORD_W-1:0] maskOf(input logic [4:0] l);
    logic [16:0] m;
    m = (17'h1 << l) - 17'h1;
    return m[WORD_W-1:0];
  endfunction

  // Slave link: the external master's clock shifts data in
  // The count is cleared while deselected; the clock stands still then
  assign ssIdle = pinIn.pcs[0];

  always_ff @(posedge linkClk or posedge rst or posedge ssIdle) begin
    if (rst || ssIdle) begin
      linkCnt_reg <= 5'h00;
    end else if (linkCnt_reg != 5'h1f) begin
      linkCnt_reg <= linkCnt_reg + 5'h01;
    end
  end

  // Never cleared per frame; the core keeps only the last len bits
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkRx_reg <= '0;
    end else begin
      linkRx_reg <= {linkRx_reg[WORD_W-2:0], pinIn.mosi};
    end
  end

  // slaveTx and len stay fixed for the whole frame, so reading them here is safe
  always_comb begin
    slaveIdx = state_reg.len - 5'h01 - linkCnt_reg;
    slaveBit = (linkCnt_reg < state_reg.len) ? state_reg.slaveTx[slaveIdx[3:0]] : 1'b0;
  end

  always_comb begin
    state_next = state_reg;
    fin = 1'b0;
    finData = '0;
    leading = ~state_reg.edgeCnt[0];
    sampleNow = leading ^ ctrl.clockPhase;
    shiftNow = ~sampleNow && (state_reg.edgeCnt != 6'h00 || ~ctrl.clockPhase);
    state_next.misoSync = {state_reg.misoSync[0], pinIn.miso};
    state_next.ssSync = {state_reg.ssSync[0], pinIn.pcs[0]};
    state_next.ssLast = state_reg.ssSync[1];
    state_next.ownSelLow = {state_reg.ownSelLow[0], driveEn.pcs[0] && ~drive.pcs[0]};

    // Host owns command and transmit RAM; the port only reads them
    if (hostWrite && hostSeg == SEG_CMD) begin
      state_next.cmdMem[hostIndex] = hostWrData[7:0];
    end
    if (hostWrite && hostSeg == SEG_TX) begin
      state_next.txMem[hostIndex] = hostWrData;
    end
    case (hostSeg)
      SEG_CMD: state_next.rdData = {8'h00, state_reg.cmdMem[hostIndex]};
      SEG_TX: state_next.rdData = state_reg.txMem[hostIndex];
      SEG_RX: state_next.rdData = state_reg.rxMem[hostIndex];
      default: state_next.rdData = '0;
    endcase

    if (enableSet) begin
      state_next.en = 1'b1;
    end
    if (enableClear) begin
      state_next.en = 1'b0;
    end

    case (state_reg.st)
      ST_IDLE: begin
        if (state_reg.en && ctrl.masterSel) begin
          state_next.st = ST_LOAD;
        end else if (state_reg.en && ~state_reg.ssSync[1] && state_reg.ssLast) begin
          state_next.slaveTx = state_reg.txMem[state_reg.workPtr];
          state_next.len = lenOf(state_reg.cmdMem[state_reg.workPtr], ctrl.bitsField);
          state_next.st = ST_SLAVE;
        end
      end
      ST_LOAD: begin
        // Left-justify the word so the top bit leaves first
        state_next.cmd = state_reg.cmdMem[state_reg.workPtr];
        state_next.len = lenOf(state_next.cmd, ctrl.bitsField);
        state_next.txSh = state_reg.txMem[state_reg.workPtr] << (MAX_LEN - state_next.len);
        state_next.rxSh = '0;
        state_next.pcs = state_next.cmd[CMD_CS_LSB +: 4];
        state_next.sck = ctrl.clockPolarity;
        state_next.edgeCnt = 6'h00;
        state_next.timer = SCK_HALF_CYCLES;
        state_next.st = ST_SETUP;
      end
      ST_SETUP: begin
        state_next.timer = state_reg.timer - 8'h01;
        if (state_reg.timer == 8'h01) begin
          state_next.timer = SCK_HALF_CYCLES;
          state_next.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        state_next.timer = state_reg.timer - 8'h01;
        if (state_reg.timer == 8'h01) begin
          state_next.timer = SCK_HALF_CYCLES;
          state_next.sck = ~state_reg.sck;
          state_next.edgeCnt = state_reg.edgeCnt + 6'h01;
          if (sampleNow) begin
            state_next.rxSh = {state_reg.rxSh[WORD_W-2:0], state_reg.misoSync[1]};
          end
          if (shiftNow) begin
            state_next.txSh = state_reg.txSh << 1;
          end
          if (state_reg.edgeCnt == {state_reg.len, 1'b0} - 6'h01) begin
            state_next.st = ST_STORE;
          end
        end
        if (~state_reg.en) begin
          state_next.st = ST_IDLE;
          state_next.pcs = 4'hf;
          state_next.sck = ctrl.clockPolarity;
        end
      end
      ST_STORE: begin
        fin = 1'b1;
        finData = state_reg.rxSh;
        if (~state_reg.cmd[CMD_CONT_BIT]) begin
          state_next.pcs = 4'hf;
        end
        state_next.timer = GAP_CYCLES;
        state_next.st = ST_GAP;
      end
      ST_GAP: begin
        state_next.timer = state_reg.timer - 8'h01;
        if (state_reg.timer == 8'h01) begin
          state_next.st = ST_IDLE;
          if (state_reg.en && ctrl.masterSel) begin
            state_next.st = ST_LOAD;
          end else begin
            state_next.pcs = 4'hf;
          end
        end
      end
      ST_SLAVE: begin
        if (state_reg.ssSync[1] && ~state_reg.ssLast) begin
          fin = 1'b1;
          finData = linkRx_reg & maskOf(state_reg.len);
          state_next.st = ST_IDLE;
        end
      end
      default: state_next.st = ST_IDLE;
    endcase

    if (fin) begin
      state_next.rxMem[state_reg.workPtr] = finData;
      state_next.cptPtr = state_reg.workPtr;
      state_next.workPtr = state_reg.pendStart ? state_reg.startPtr : state_reg.workPtr + 4'h1;
      state_next.pendStart = 1'b0;
      if (state_reg.workPtr == state_reg.endPtr) begin
        state_next.doneFlag = 1'b1;
        if (ctrl.wrapEnable) begin
          state_next.workPtr = state_reg.startPtr;
        end else begin
          state_next.en = 1'b0;
        end
      end
    end

    if (ptrWrite) begin
      state_next.startPtr = startPtrIn;
      state_next.endPtr = endPtrIn;
      if (state_next.st == ST_IDLE && ~fin) begin
        state_next.workPtr = startPtrIn;
      end else begin
        state_next.pendStart = 1'b1;
      end
    end

    // Event wins over a clear in the same cycle
    if (doneClear && ~(fin && state_reg.workPtr == state_reg.endPtr)) begin
      state_next.doneFlag = 1'b0;
    end
    if (faultClear) begin
      state_next.faultFlag = 1'b0;
    end
    // Our own select driven low is not a fault; the history covers the synchroniser lag
    if (ctrl.masterSel && ~state_reg.ssSync[1] && ~(driveEn.pcs[0] && ~drive.pcs[0]) &&
        ~(|state_reg.ownSelLow)) begin
      state_next.faultFlag = 1'b1;
    end
    state_next.irq = state_next.doneFlag && ctrl.doneIrqEnable;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{st: ST_IDLE, startPtr: PTR_RESET, endPtr: PTR_RESET,
                     workPtr: PTR_RESET, cptPtr: PTR_RESET, len: DEFAULT_LEN,
                     pcs: 4'hf, misoSync: 2'h3, ssSync: 2'h3, ssLast: 1'b1,
                     default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin drivers: master pins need enable and masterSel; miso needs enable, slave role and select
  always_comb begin
    drive.sck = state_reg.sck;
    drive.mosi = state_reg.txSh[WORD_W-1];
    drive.miso = slaveBit;
    drive.pcs = state_reg.pcs;
    driveEn.sck = state_reg.en && ctrl.masterSel;
    driveEn.mosi = state_reg.en && ctrl.masterSel;
    driveEn.miso = state_reg.en && ~ctrl.masterSel && ~ssIdle;
    driveEn.pcs = {4{state_reg.en && ctrl.masterSel}};
  end

  // Open-drain drives only lows and leaves highs to the pull-up
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pin
      assign pinOut[gi] = ctrl.openDrain ? 1'b0 : drive[gi];
      assign pinOe[gi] = ctrl.openDrain ? (driveEn[gi] && ~drive[gi]) : driveEn[gi];
    end
  endgenerate

  assign portEnable = state_reg.en;
  assign queueStartPointer = state_reg.startPtr;
  assign queueEndPointer = state_reg.endPtr;
  assign completedEntryPointer = state_reg.cptPtr;
  assign queueDoneFlag = state_reg.doneFlag;
  assign modeFaultFlag = state_reg.faultFlag;
  assign doneIrq = state_reg.irq;
  assign hostRdData = state_reg.rdData;

endmodule
`default_nettype wire

/* rtl/queue_serial_pkg.sv */
// Functional notes
// - Transmit RAM is never written by the port
// - Transmit words persist until host overwrites them
// - Sixteen read-only command bytes drive master mode
// - Command byte holds selects plus control options
// - Run entries from start through end pointer
// - Entry index picks command, transmit, receive items
// - Execute, record completed pointer, increment, repeat
// - Working pointer follows start pointer writes
// - End equals completed: set done, stop unless wrapping
// - Reset clears start and end pointers
// - Start write mid-transfer waits for transfer end
// - Both pointers zero gives exactly one transfer
// - Master drives selects, sends, stores received word
// - Control bit selects master or slave role
// - Slave drives no selects, runs entry per select
// - Select input in master sets mode fault only
// - Phase and polarity bits pick four modes; the slave link always uses the rising linkClk edge
// - MSB first, eight bits default, up to sixteen
// - Wired-OR bit makes all seven pins open-drain
// - Done with enable raises request; stop unless wrapping
// - Receive words right-justified, upper bits zeroed
// - Length-select bit picks default or programmed length
// - Only the port sets flags; host clears them
package queue_serial_pkg;
  localparam int ENTRIES = 16;
  localparam int WORD_W = 16;
  localparam logic [4:0] DEFAULT_LEN = 5'h08;
  localparam logic [4:0] MAX_LEN = 5'h10;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam int CMD_CS_LSB = 0;
  localparam int CMD_LENSEL_BIT = 4;
  localparam int CMD_CONT_BIT = 5;
  localparam logic [1:0] SEG_CMD = 2'h0;
  localparam logic [1:0] SEG_TX = 2'h1;
  localparam logic [1:0] SEG_RX = 2'h2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_HALF_NS = 16;
  localparam logic [7:0] SCK_HALF_CYCLES = 8'(SCK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_CYCLES = 8'h11;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_LOAD = 7'h02, ST_SETUP = 7'h04, ST_SHIFT = 7'h08,
    ST_STORE = 7'h10, ST_GAP = 7'h20, ST_SLAVE = 7'h40
  } state_t;

  typedef struct packed {
    logic masterSel;
    logic clockPolarity;
    logic clockPhase;
    logic openDrain;
    logic wrapEnable;
    logic doneIrqEnable;
    logic [3:0] bitsField;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] pcs;
    logic miso;
    logic mosi;
    logic sck;
  } pins_t;
endpackage

/* tb/queue_engine_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module queue_engine_properties
  import queue_serial_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Controls
  input wire ctrl_t ctrl,
  input wire logic enableClear,
  input wire logic ptrWrite,
  input wire logic [3:0] startPtrIn,
  input wire logic [3:0] endPtrIn,
  // Outputs watched
  input wire logic portEnable,
  input wire logic [3:0] queueStartPointer,
  input wire logic [3:0] queueEndPointer,
  input wire logic [3:0] completedEntryPointer,
  input wire logic queueDoneFlag,
  input wire logic modeFaultFlag,
  input wire logic doneIrq,
  input wire pins_t pinOut,
  input wire pins_t pinOe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence queueEnds;
    $rose(queueDoneFlag) ##0 !ctrl.wrapEnable;
  endsequence
  sequence portIdle;
    !portEnable [*4];
  endsequence
  done_stops_a: assert property (queueEnds |-> ##[0:3] !portEnable)
    else $error("enable kept after queue end");
  irq_follows_a: assert property (doneIrq == (queueDoneFlag && $past(ctrl.doneIrqEnable)))
    else $error("done request wrong");
  done_at_end_a: assert property ($rose(queueDoneFlag) |-> completedEntryPointer == queueEndPointer)
    else $error("done away from end entry");
  fault_keeps_run_a: assert property ($rose(modeFaultFlag) && portEnable && !enableClear && ctrl.wrapEnable
    |=> portEnable) else $error("fault dropped enable");
  ptr_write_a: assert property (ptrWrite |=> queueStartPointer == $past(startPtrIn)
    && queueEndPointer == $past(endPtrIn)) else $error("pointer write lost");
  slave_no_selects_a: assert property (!ctrl.masterSel [*2] |-> pinOe.pcs == 4'h0)
    else $error("selects driven in slave role");
  open_drain_a: assert property (ctrl.openDrain [*3] |-> pinOut == 7'h00)
    else $error("pin driven high in open drain");
  released_pins_a: assert property (portIdle |-> pinOe == 7'h00)
    else $error("pins driven while disabled");
  sck_idle_a: assert property ($fell(pinOut.pcs[0]) && pinOe.pcs[0] && !ctrl.openDrain
    |-> pinOut.sck == ctrl.clockPolarity) else $error("clock not idle at select");
endmodule
`default_nettype wire

/* tb/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Bus wires
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  output logic miso,
  // Observation
  output logic [15:0] gotWord
);
  logic [15:0] sh = 16'h0000;
  logic [7:0] frameCount = 8'h00;
  logic first = 1'b1;
  initial gotWord = 16'h0000;
  // Reply depends on frame number so every word differs
  always @(negedge selN) begin
    sh = {frameCount ^ 8'h5a, frameCount ^ 8'hc3};
    frameCount = frameCount + 8'h01;
    first = 1'b1;
  end
  // Capture edge and shift edge follow the phase and polarity setting
  always @(sck) begin
    if (!selN && (sck === 1'b0 || sck === 1'b1)) begin
      if ((sck != clock_polarity_bit) ^ clock_phase_bit) begin
        gotWord = {gotWord[14:0], mosi};
      end else if (clock_phase_bit && first) begin
        first = 1'b0;
      end else begin
        sh = sh << 1;
      end
    end
  end
  // Pull-up holds the line high once released
  assign miso = selN ? 1'b1 : sh[15];
endmodule
`default_nettype wire

/* tb/queued_serial_master_queue_test.sv */
`timescale 1ns/1ps
`default_nettype none
module queued_serial_master_queue_test
  import queue_serial_pkg::*;
;
  logic core_clk = 0, rst = 1, linkClk = 0, ssForce = 0;
  ctrl_t ctrl;
  pins_t pinIn, pinOut, pinOe;
  logic [5:0] strobe;
  logic enableSet, enableClear, ptrWrite, doneClear, faultClear, hostWrite, peerMiso;
  logic portEnable, queueDoneFlag, modeFaultFlag, doneIrq;
  logic [1:0] hostSeg;
  logic [3:0] startPtrIn, endPtrIn, hostIndex, queueStartPointer, queueEndPointer, completedEntryPointer;
  logic [15:0] hostWrData, hostRdData, peerWord, rd;
  logic [15:0] txShadow [16], rxShadow [16];
  logic [31:0] note;
  logic [31:0] expQ [$];
  logic [6:0] lvl;
  int n_errors = 0, n_compared = 0, frames = 0, sent = 0;
  always #2 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #6 linkClk = ~linkClk;
  end
  assign {hostWrite, faultClear, doneClear, ptrWrite, enableClear, enableSet} = strobe;
  // Every pin has a pull-up, so a released pin reads high
  assign lvl = ~pinOe | pinOut;
  assign pinIn = {lvl[6:4], lvl[3] & ~ssForce, lvl[2] & peerMiso, lvl[1:0]};
  queued_serial_master_queue dut (.core_clk, .rst, .linkClk, .ctrl, .enableSet, .enableClear, .portEnable,
    .ptrWrite, .startPtrIn, .endPtrIn, .queueStartPointer, .queueEndPointer, .completedEntryPointer,
    .doneClear, .faultClear, .queueDoneFlag, .modeFaultFlag, .doneIrq, .hostWrite, .hostSeg, .hostIndex,
    .hostWrData, .hostRdData, .pinIn, .pinOut, .pinOe);
  serial_peer peer (.sck(lvl[0]), .mosi(lvl[1]), .selN(lvl[3]), .clock_polarity_bit(ctrl.clockPolarity), .clock_phase_bit(ctrl.clockPhase),
    .miso(peerMiso), .gotWord(peerWord));
  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(logic [5:0] m);
    @(posedge core_clk);
    strobe <= m;
    @(posedge core_clk);
    strobe <= 6'h00;
    #1;
  endtask
  task automatic hostWr(logic [1:0] s, logic [3:0] i, logic [15:0] d);
    hostSeg <= s;
    hostIndex <= i;
    hostWrData <= d;
    pulse(6'h20);
  endtask
  task automatic hostRd(logic [1:0] s, logic [3:0] i);
    @(posedge core_clk);
    hostSeg <= s;
    hostIndex <= i;
    repeat (2) @(posedge core_clk);
    #1;
    rd = hostRdData;
  endtask
  task automatic waitDone();
    int k;
    k = 0;
    while (queueDoneFlag !== 1'b1 && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 4000) begin
      check("done wait", 16'h1, 16'h0);
      test_done();
    end
  endtask
  // Expected mosi word and reply are noted before the queue starts
  task automatic runQueue(logic [3:0] s, logic [3:0] e, logic [3:0] bits);
    int len, f0;
    ctrl.bitsField <= bits;
    startPtrIn <= s;
    endPtrIn <= e;
    if (s || e) pulse(6'h04);
    f0 = frames;
    for (int i = s; i <= e; i++) begin
      len = (i % 2 == 0) ? ((bits == 0) ? 16 : (bits < 8) ? 8 : bits) : 8;
      rxShadow[i] = {sent[7:0] ^ 8'h5a, sent[7:0] ^ 8'hc3} >> (16 - len);
      expQ.push_back({16'(len), txShadow[i] & 16'((17'h1 << len) - 17'h1)});
      sent++;
    end
    pulse(6'h01);
    waitDone();
    repeat (20) @(posedge core_clk);
    check("completed ptr", 16'(e), 16'(completedEntryPointer));
    check("frames", 16'(e - s + 1), 16'(frames - f0));
    check("enable", 16'h0, 16'(portEnable));
    check("irq", 16'h1, 16'(doneIrq));
    pulse(6'h08);
    check("done clear", 16'h0, 16'(queueDoneFlag));
    for (int i = s; i <= e; i++) begin
      hostRd(SEG_RX, 4'(i));
      check("rx word", rxShadow[i], rd);
      hostRd(SEG_TX, 4'(i));
      check("tx word", txShadow[i], rd);
    end
  endtask
  always @(posedge lvl[3]) begin
    #1;
    frames++;
    if (expQ.size() > 0) begin
      note = expQ.pop_front();
      check("mosi word", note[15:0], peerWord & 16'((17'h1 << note[31:16]) - 17'h1));
    end
  end
  initial begin
    void'($urandom(32'hf80e));
    ctrl = '0;
    strobe = 6'h00;
    {hostSeg, hostIndex, hostWrData, startPtrIn, endPtrIn} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check("start ptr", 16'h0, 16'(queueStartPointer));
    check("end ptr", 16'h0, 16'(queueEndPointer));
    check("flags", 16'h0, 16'({queueDoneFlag, modeFaultFlag, portEnable}));
    for (int i = 0; i < 16; i++) begin
      txShadow[i] = 16'($urandom);
      hostWr(SEG_TX, 4'(i), txShadow[i]);
      hostWr(SEG_CMD, 4'(i), {11'h0, i % 2 == 0, 4'he});
    end
    ctrl.masterSel <= 1'b1;
    ctrl.doneIrqEnable <= 1'b1;
    runQueue(4'h0, 4'h0, 4'h8);
    runQueue(4'h3, 4'h6, 4'hc);
    ctrl.openDrain <= 1'b1;
    runQueue(4'he, 4'hf, 4'h0);
    ctrl.openDrain <= 1'b0;
    ctrl.clockPhase <= 1'b1;
    runQueue(4'h9, 4'ha, 4'h3);
    ctrl.clockPhase <= 1'b0;
    hostRd(2'h3, 4'h0);
    check("unmapped", 16'h0, rd);
    ctrl.wrapEnable <= 1'b1;
    ctrl.clockPolarity <= 1'b1;
    startPtrIn <= 4'h0;
    endPtrIn <= 4'h1;
    pulse(6'h04);
    pulse(6'h01);
    waitDone();
    check("wrap enable", 16'h1, 16'(portEnable));
    ssForce <= 1'b1;
    repeat (100) @(posedge core_clk);
    ssForce <= 1'b0;
    #1;
    check("mode fault", 16'h1, 16'(modeFaultFlag));
    check("fault enable", 16'h1, 16'(portEnable));
    startPtrIn <= 4'h8;
    endPtrIn <= 4'h8;
    pulse(6'h04);
    ctrl.wrapEnable <= 1'b0;
    pulse(6'h08);
    waitDone();
    check("new start", 16'h8, 16'(completedEntryPointer));
    pulse(6'h12);
    check("fault clear", 16'h0, 16'(modeFaultFlag));
    test_done();
  end
endmodule
bind queued_serial_master_queue queue_engine_properties chk (.core_clk, .rst, .ctrl, .enableClear, .ptrWrite,
  .startPtrIn, .endPtrIn, .portEnable, .queueStartPointer, .queueEndPointer, .completedEntryPointer,
  .queueDoneFlag, .modeFaultFlag, .doneIrq, .pinOut, .pinOe);
`default_nettype wire
